// ===== src/pll_ctrl_pkg.sv
package pll_ctrl_pkg;

	// Clock rate of ref_clk
	localparam int CLK_MHZ = 200;

	// Times in nanoseconds
	localparam int FAULT_TIME_NS  = 1000;
	localparam int PHASE_STEP_NS  = 100;
	localparam int RECONF_TIME_NS = 500;

	// Derived cycle counts
	localparam int FAULT_CYCLES  = (FAULT_TIME_NS * CLK_MHZ) / 1000;
	localparam int PHASE_CYCLES  = (PHASE_STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int RECONF_CYCLES = (RECONF_TIME_NS * CLK_MHZ + 999) / 1000;

	// Reference edges counted before lock is shown
	localparam int GATE_LOCK_EDGES = 16;

	// Counter widths
	localparam int FAULT_CW  = $clog2(FAULT_CYCLES + 1);
	localparam int LOCK_CW   = $clog2(GATE_LOCK_EDGES + 1);
	localparam int PHASE_CW  = $clog2(PHASE_CYCLES + 1);
	localparam int RECONF_CW = $clog2(RECONF_CYCLES + 1);

	// Bit positions in the synchronised pin vector
	localparam int IN_REF0   = 0;
	localparam int IN_REF1   = 1;
	localparam int IN_SCLK   = 2;
	localparam int IN_CRST   = 3;
	localparam int IN_TOGGLE = 4;
	localparam int IN_SEL    = 5;
	localparam int IN_DET    = 6;
	localparam int IN_STEP   = 7;
	localparam int IN_UP     = 8;
	localparam int IN_SGATE  = 9;
	localparam int IN_SDATA  = 10;
	localparam int IN_CUPD   = 11;
	localparam int IN_TGT    = 12;
	localparam int TGT_W     = 3;
	localparam int SYNC_W    = IN_TGT + TGT_W;

	// Phase target encodings; C0..C4 are TGT_C0 upward
	localparam logic [TGT_W-1:0] TGT_ALL = 3'h0;
	localparam logic [TGT_W-1:0] TGT_FB  = 3'h1;
	localparam logic [TGT_W-1:0] TGT_C0  = 3'h2;
	localparam int NUM_CNT = 6;
	localparam int PHASE_W = 5;

	// Scan chain length
	localparam int SCAN_LEN = 32;

	// APB map
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_PHASE  = 8'h08;
	localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h0c;
	localparam int CTRL_AUTO = 0;
	localparam int ST_ACTIVE = 0;
	localparam int ST_FAULT0 = 1;
	localparam int ST_FAULT1 = 2;
	localparam int ST_LOCK   = 3;
	localparam int ST_PDONE  = 4;
	localparam int ST_SCAN   = 5;
	localparam int ST_DET    = 6;

endpackage

// ===== src/pll_control_port_logic.sv
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps

module pll_control_port_logic
	import pll_ctrl_pkg::*;
(
	input  wire logic               ref_clk,                 // System clock
	input  wire logic               sys_rst,                 // Sync reset, high
	input  wire logic               primaryReferenceClock,   // Reference clock 0
	input  wire logic               secondaryReferenceClock, // Reference clock 1
	input  wire logic               scanClock,               // Serial-chain clock
	input  wire logic               counterReset,            // Counter reset
	input  wire logic               sourceToggle,            // Manual switch
	input  wire logic               clockSelect,             // Initial source
	input  wire logic               detectorEnable,          // Detector enable
	input  wire logic               phaseStep,               // Step request
	input  wire logic               phaseUp,                 // Step direction
	input  wire logic [TGT_W-1:0]   phaseTarget,             // Step target
	input  wire logic               scanClockGate,           // Chain shift gate
	input  wire logic               scanData,                // Chain data in
	input  wire logic               configUpdate,            // Reconfigure
	input  wire logic               psel,                    // APB select
	input  wire logic               penable,                 // APB enable
	input  wire logic               pwrite,                  // APB write
	input  wire logic [ADDR_W-1:0]  paddr,                   // APB address
	input  wire logic [31:0]        pwdata,                  // APB write data
	output logic [31:0]             prdata,                  // APB read data
	output logic                    pready,                  // APB ready
	output logic                    pslverr,                 // APB error
	output logic                    activeSource,            // 0 primary, 1 secondary
	output logic                    primaryFaultFlag,        // Primary stopped
	output logic                    secondaryFaultFlag,      // Secondary stopped
	output logic                    lockIndication,          // Locked
	output logic                    phaseDone,               // Step complete
	output logic                    scanWriteBusy,           // Reconfig running
	output logic                    detectorEnabled          // Detector running
);

	typedef struct packed {
		logic [SYNC_W-1:0]           syncA;
		logic [SYNC_W-1:0]           syncB;
		logic [SYNC_W-1:0]           prev;
		logic [FAULT_CW-1:0]         watch0;
		logic [FAULT_CW-1:0]         watch1;
		logic                        fault0;
		logic                        fault1;
		logic                        active;
		logic                        autoEn;
		logic                        detOn;
		logic [LOCK_CW-1:0]          lockCnt;
		logic                        locked;
		logic [TGT_W-1:0]            target;
		logic                        up;
		logic [PHASE_CW-1:0]         phaseBusy;
		logic                        phaseDone;
		logic [NUM_CNT*PHASE_W-1:0]  offs;
		logic [SCAN_LEN-1:0]         chain;
		logic [SCAN_LEN-1:0]         cfgLive;
		logic [RECONF_CW-1:0]        scanCnt;
		logic                        scanWrite;
		logic                        pready;
		logic                        pslverr;
		logic [31:0]                 prdata;
	} state_t;

	localparam logic [FAULT_CW-1:0]  FAULT_LIMIT = FAULT_CW'(FAULT_CYCLES);
	localparam logic [LOCK_CW-1:0]   LOCK_LIMIT  = LOCK_CW'(GATE_LOCK_EDGES);
	localparam logic [PHASE_CW-1:0]  PHASE_LOAD  = PHASE_CW'(PHASE_CYCLES);
	localparam logic [RECONF_CW-1:0] RECONF_LOAD = RECONF_CW'(RECONF_CYCLES);
	localparam logic [PHASE_W-1:0]   PH_ONE      = 5'h01;
	localparam int PH_WAIT = PHASE_CYCLES;
	localparam int RC_WAIT = RECONF_CYCLES;

	state_t                 st;
	state_t                 next_st;
	logic [SYNC_W-1:0]      pinsRaw;
	logic [SYNC_W-1:0]      rise;
	logic                   ctrRst;
	logic                   scanRise;
	logic                   refRise;
	logic                   activeFault;
	logic                   stepAcc;
	logic                   switchEvt;
	logic [TGT_W-1:0]       tgtNow;
	logic [31:0]            statusWord;

	// Pins gathered for the synchroniser
	assign pinsRaw = {phaseTarget, configUpdate, scanData, scanClockGate, phaseUp,
		phaseStep, detectorEnable, clockSelect, sourceToggle, counterReset,
		scanClock, secondaryReferenceClock, primaryReferenceClock};

	// Edges and qualified events, from the second stage only
	assign rise        = st.syncB & ~st.prev;
	assign ctrRst      = st.syncB[IN_CRST];
	assign scanRise    = rise[IN_SCLK];
	assign tgtNow      = st.syncB[IN_TGT +: TGT_W];
	assign activeFault = st.active ? st.fault1 : st.fault0;
	assign refRise     = st.active ? rise[IN_REF1] : rise[IN_REF0];
	assign stepAcc     = scanRise && st.syncB[IN_STEP] && (st.phaseBusy == '0);
	assign switchEvt   = rise[IN_TOGGLE]
		|| (st.autoEn && !st.active && st.fault0 && !st.fault1);

	// Status word
	always_comb begin
		statusWord = '0;
		statusWord[ST_ACTIVE] = st.active;
		statusWord[ST_FAULT0] = st.fault0;
		statusWord[ST_FAULT1] = st.fault1;
		statusWord[ST_LOCK]   = st.locked;
		statusWord[ST_PDONE]  = st.phaseDone;
		statusWord[ST_SCAN]   = st.scanWrite;
		statusWord[ST_DET]    = st.detOn;
	end

	// Next state
	always_comb begin
		next_st = st;

		// Two-stage synchroniser and edge history
		next_st.syncA = pinsRaw;
		next_st.syncB = st.syncA;
		next_st.prev  = st.syncB;

		// Stopped-clock watchdogs
		if (rise[IN_REF0]) begin
			next_st.watch0 = '0;
			next_st.fault0 = 1'b0;
		end else if (st.watch0 != FAULT_LIMIT) begin
			next_st.watch0 = st.watch0 + 1'b1;
		end else begin
			next_st.fault0 = 1'b1;
		end
		if (rise[IN_REF1]) begin
			next_st.watch1 = '0;
			next_st.fault1 = 1'b0;
		end else if (st.watch1 != FAULT_LIMIT) begin
			next_st.watch1 = st.watch1 + 1'b1;
		end else begin
			next_st.fault1 = 1'b1;
		end

		// Detector enable follows its pin
		next_st.detOn = st.syncB[IN_DET];

		// Source selection and lock gating
		if (ctrRst) begin
			next_st.active  = st.syncB[IN_SEL];
			next_st.lockCnt = '0;
			next_st.locked  = 1'b0;
			next_st.offs    = '0;
		end else if (switchEvt) begin
			// Manual toggle and the automatic path share one source flip
			next_st.active  = !st.active;
			next_st.lockCnt = '0;
			next_st.locked  = 1'b0;
		end else if (activeFault) begin
			next_st.lockCnt = '0;
			next_st.locked  = 1'b0;
		end else if (refRise && st.detOn) begin
			// Gating frozen while the detector is off
			if (st.lockCnt != LOCK_LIMIT) begin
				next_st.lockCnt = st.lockCnt + 1'b1;
			end
			if (st.lockCnt == LOCK_LIMIT - 1'b1) begin
				next_st.locked = 1'b1;
			end
		end

		// Capture target and direction on chain clock rise
		if (scanRise) begin
			next_st.target = tgtNow;
			next_st.up     = st.syncB[IN_UP];
		end

		// Phase step engine
		if (st.phaseBusy != '0) begin
			next_st.phaseBusy = st.phaseBusy - 1'b1;
		end
		if (scanRise) begin
			next_st.phaseDone = 1'b0;
		end
		if (st.phaseBusy == PHASE_CW'(1)) begin
			next_st.phaseDone = 1'b1;
		end
		if (stepAcc && !ctrRst) begin
			next_st.phaseBusy = PHASE_LOAD;
			for (int i = 0; i < NUM_CNT; i++) begin
				if ((tgtNow == TGT_W'(i + 1)) || (tgtNow == TGT_ALL && i != 0)) begin
					if (st.syncB[IN_UP]) begin
						next_st.offs[i*PHASE_W +: PHASE_W] =
							st.offs[i*PHASE_W +: PHASE_W] + PH_ONE;
					end else begin
						next_st.offs[i*PHASE_W +: PHASE_W] =
							st.offs[i*PHASE_W +: PHASE_W] - PH_ONE;
					end
				end
			end
		end

		// Scan chain shift
		if (scanRise && st.syncB[IN_SGATE]) begin
			next_st.chain = {st.chain[SCAN_LEN-2:0], st.syncB[IN_SDATA]};
		end

		// Full reconfiguration
		if (st.scanCnt != '0) begin
			next_st.scanCnt = st.scanCnt - 1'b1;
			if (st.scanCnt == RECONF_CW'(1)) begin
				next_st.scanWrite = 1'b0;
			end
		end else if (rise[IN_CUPD]) begin
			next_st.scanCnt   = RECONF_LOAD;
			next_st.scanWrite = 1'b1;
			next_st.cfgLive   = st.chain;
		end

		// APB slave: one wait-free access phase
		next_st.pready  = psel && !penable && !st.pready;
		next_st.pslverr = 1'b0;
		next_st.prdata  = '0;
		if (psel && !penable) begin
			if (paddr == REG_CTRL) begin
				next_st.prdata[CTRL_AUTO] = st.autoEn;
			end else if (paddr == REG_STATUS) begin
				next_st.prdata = statusWord;
			end else if (paddr == REG_PHASE) begin
				next_st.prdata[NUM_CNT*PHASE_W-1:0] = st.offs;
			end else if (paddr == REG_CONFIG) begin
				next_st.prdata = st.cfgLive;
			end else begin
				next_st.pslverr = 1'b1;
			end
		end
		if (psel && penable && st.pready && pwrite && paddr == REG_CTRL) begin
			next_st.autoEn = pwdata[CTRL_AUTO];
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from flops
	assign prdata             = st.prdata;
	assign pready             = st.pready;
	assign pslverr            = st.pslverr;
	assign activeSource       = st.active;
	assign primaryFaultFlag   = st.fault0;
	assign secondaryFaultFlag = st.fault1;
	assign lockIndication     = st.locked;
	assign phaseDone          = st.phaseDone;
	assign scanWriteBusy      = st.scanWrite;
	assign detectorEnabled    = st.detOn;

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence stepTaken;
		stepAcc && !ctrRst;
	endsequence

	sequence updateTaken;
		rise[IN_CUPD] && st.scanCnt == '0;
	endsequence

	a_ctr_reset_clear: assert property (
		ctrRst |=> !lockIndication && st.lockCnt == '0 && st.offs == '0)
		else $error("counter reset did not clear counters");

	a_toggle_swap: assert property (
		rise[IN_TOGGLE] && !ctrRst |=> activeSource != $past(activeSource))
		else $error("toggle did not swap source");

	a_auto_switch: assert property (
		st.autoEn && !activeSource && primaryFaultFlag && !secondaryFaultFlag
			&& !ctrRst |=> activeSource)
		else $error("automatic switchover missing");

	a_det_freeze: assert property (
		!detectorEnabled && !ctrRst |=> !$rose(lockIndication))
		else $error("lock rose with detector off");

	a_fault_time: assert property (
		$rose(primaryFaultFlag) |-> $past(st.watch0) == FAULT_LIMIT
			&& !$past(rise[IN_REF0]))
		else $error("primary fault at wrong time");

	a_step_done: assert property (
		stepTaken |=> !phaseDone ##PH_WAIT phaseDone)
		else $error("phase done timing wrong");

	a_done_fall: assert property (
		phaseDone && scanRise && st.phaseBusy != PHASE_CW'(1) |=> !phaseDone)
		else $error("phase done did not fall");

	a_step_fb_up: assert property (
		stepTaken and (tgtNow == TGT_FB && st.syncB[IN_UP])
		|=> st.offs[PHASE_W-1:0] == $past(st.offs[PHASE_W-1:0]) + PH_ONE)
		else $error("feedback step up wrong");

	a_step_all: assert property (
		stepTaken and (tgtNow == TGT_ALL)
		|=> st.offs[PHASE_W-1:0] == $past(st.offs[PHASE_W-1:0])
		&& st.offs[2*PHASE_W-1:PHASE_W] != $past(st.offs[2*PHASE_W-1:PHASE_W])
		&& st.offs[6*PHASE_W-1:5*PHASE_W] != $past(st.offs[6*PHASE_W-1:5*PHASE_W]))
		else $error("all-outputs step wrong");

	a_scan_write: assert property (
		updateTaken |=> scanWriteBusy ##RC_WAIT !scanWriteBusy)
		else $error("scan write flag timing wrong");

	a_chain_shift: assert property (
		scanRise && st.syncB[IN_SGATE] |=> st.chain[0] == $past(st.syncB[IN_SDATA]))
		else $error("chain did not shift");

endmodule // pll_control_port_logic

// ===== test/core_clock_model.sv
`timescale 1ns/1ps

// Core-side source of the two references and the serial-chain clock
module core_clock_model (
	input  wire logic ref_clk,                 // Bench clock
	input  wire logic run0,                    // Primary reference runs
	input  wire logic run1,                    // Secondary reference runs
	output logic      primaryReferenceClock,   // 40 ns when running
	output logic      secondaryReferenceClock, // 80 ns when running
	output logic      scanClock                // 160 ns, never stops
);
	logic [3:0] cnt;

	// Known levels before the first edge
	initial begin
		cnt = 4'h0;
		primaryReferenceClock = 1'b0;
		secondaryReferenceClock = 1'b0;
		scanClock = 1'b0;
	end

	// Divide the bench clock; a stopped reference holds its level
	always @(posedge ref_clk) begin
		cnt <= cnt + 4'h1;
		if (run0 && cnt[1:0] == 2'h3) primaryReferenceClock <= !primaryReferenceClock;
		if (run1 && cnt[2:0] == 3'h7) secondaryReferenceClock <= !secondaryReferenceClock;
		if (cnt == 4'hf) scanClock <= !scanClock;
	end
endmodule // core_clock_model

// ===== test/pll_control_port_logic_bench.sv
`timescale 1ns/1ps

module pll_control_port_logic_bench;
	import pll_ctrl_pkg::*;
	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic x;} row_t;
	logic ref_clk = 0, sys_rst = 1, run0 = 1, run1 = 1;
	logic primaryReferenceClock, secondaryReferenceClock, scanClock;
	logic counterReset = 1, sourceToggle = 0, clockSelect = 0, detectorEnable = 1;
	logic phaseStep = 0, phaseUp = 0, scanClockGate = 0, scanData = 0, configUpdate = 0;
	logic [2:0] phaseTarget = 3'h0;
	logic psel = 0, penable = 0, pwrite = 0, pslverr, pready, er;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic activeSource, primaryFaultFlag, secondaryFaultFlag, lockIndication;
	logic phaseDone, scanWriteBusy, detectorEnabled;
	logic [29:0] ph = 30'h0;
	logic [31:0] pat = 32'ha5c30f96;
	int err_total = 0, checks = 0;
	row_t rows[7] = '{
		'{REG_CTRL, 1, 32'h1, 32'h0, 0}, '{REG_CTRL, 0, 32'h0, 32'h1, 0},
		'{REG_CTRL, 1, 32'h0, 32'h0, 0}, '{REG_CTRL, 0, 32'h0, 32'h0, 0},
		'{8'h10, 0, 32'h0, 32'h0, 1}, '{8'h10, 1, 32'h5, 32'h0, 1},
		'{REG_PHASE, 0, 32'h0, 32'h0, 0}};

	pll_control_port_logic dut (.*);
	core_clock_model partner (.*);

	// Bench clock
	always #2.5 ref_clk = !ref_clk;

	task chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask

	task chk_flag(input logic got, input logic exp, input string m);
		chk_word({31'h0, got}, {31'h0, exp}, m);
	endtask

	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk_flag(pready, 1, "apb answer");
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic wait_sig(ref logic s, input logic v, input int lim, input string m);
		int n = 0;
		while (s !== v && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		chk_flag(s, v, m);
	endtask

	task scan_edge(input logic v);
		while (scanClock === v) @(posedge ref_clk);
		while (scanClock !== v) @(posedge ref_clk);
	endtask

	task step(input logic [2:0] t, input logic u);
		scan_edge(0);
		phaseTarget <= t;
		phaseUp <= u;
		phaseStep <= 1;
		scan_edge(1);
		repeat (8) @(posedge ref_clk);
		phaseStep <= 0;
		wait_sig(phaseDone, 1, 100, "phase done");
	endtask

	function automatic logic [29:0] upd(logic [29:0] p, logic [2:0] t, logic u);
		for (int f = 0; f < 6; f++)
			if ((t == TGT_ALL && f > 0) || (t == TGT_FB && f == 0) ||
					(t >= TGT_C0 && t < 7 && f == t - 1))
				p[f*5 +: 5] = u ? p[f*5 +: 5] + 5'h1 : p[f*5 +: 5] - 5'h1;
		return p;
	endfunction

	task report_and_stop;
		$display("counts: checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Watchdog
	initial begin
		#100000;
		err_total++;
		$display("BAD %0t watchdog expired", $time);
		report_and_stop();
	end

	// Main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		chk_flag(lockIndication, 0, "lock in reset");
		$display("test reset done");
		repeat (3) @(posedge ref_clk);
		sys_rst <= 0;
		repeat (4) @(posedge ref_clk);
		counterReset <= 0;
		foreach (rows[i]) begin
			apb(rows[i].a, rows[i].w, rows[i].d);
			chk_flag(er, rows[i].x, "apb error");
			if (!rows[i].w) chk_word(rd, rows[i].e, "apb read");
		end
		$display("test registers done");
		wait_sig(lockIndication, 1, 600, "lock");
		apb(REG_STATUS, 0, 0);
		chk_word(rd, 32'h48, "status locked");
		$display("test lock done");
		for (int t = 0; t < 8; t++) begin
			step(3'(t), t[0]);
			ph = upd(ph, 3'(t), t[0]);
		end
		apb(REG_PHASE, 0, 0);
		chk_word(rd, {2'h0, ph}, "phase counters");
		$display("test phase done");
		clockSelect <= 1;
		counterReset <= 1;
		repeat (6) @(posedge ref_clk);
		chk_flag(lockIndication, 0, "lock after counter reset");
		counterReset <= 0;
		clockSelect <= 0;
		apb(REG_PHASE, 0, 0);
		chk_word(rd, 32'h0, "phase after counter reset");
		chk_flag(activeSource, 1, "source from select");
		sourceToggle <= 1;
		wait_sig(activeSource, 0, 10, "manual toggle");
		sourceToggle <= 0;
		$display("test counter reset done");
		detectorEnable <= 0;
		counterReset <= 1;
		repeat (6) @(posedge ref_clk);
		counterReset <= 0;
		repeat (300) @(posedge ref_clk);
		chk_flag(lockIndication, 0, "lock with detector off");
		chk_flag(detectorEnabled, 0, "detector off");
		detectorEnable <= 1;
		wait_sig(lockIndication, 1, 600, "lock after enable");
		$display("test detector done");
		apb(REG_CTRL, 1, 1);
		run0 <= 0;
		wait_sig(primaryFaultFlag, 1, 400, "primary fault");
		wait_sig(activeSource, 1, 20, "auto switch");
		chk_flag(secondaryFaultFlag, 0, "secondary good");
		run1 <= 0;
		wait_sig(secondaryFaultFlag, 1, 400, "secondary fault");
		run0 <= 1;
		run1 <= 1;
		wait_sig(primaryFaultFlag, 0, 40, "primary back");
		wait_sig(secondaryFaultFlag, 0, 40, "secondary back");
		$display("test faults done");
		for (int i = 31; i >= 0; i--) begin
			scan_edge(0);
			scanData <= pat[i];
			scanClockGate <= 1;
			scan_edge(1);
		end
		scan_edge(0);
		scanClockGate <= 0;
		scanData <= 1;
		scan_edge(1);
		scan_edge(1);
		configUpdate <= 1;
		wait_sig(scanWriteBusy, 1, 10, "scan write start");
		wait_sig(scanWriteBusy, 0, 120, "scan write end");
		configUpdate <= 0;
		apb(REG_CONFIG, 0, 0);
		chk_word(rd, pat, "live settings");
		$display("test reconfiguration done");
		sys_rst <= 1;
		repeat (2) @(posedge ref_clk);
		chk_flag(activeSource, 0, "source in second reset");
		chk_flag(lockIndication, 0, "lock in second reset");
		chk_flag(scanWriteBusy, 0, "scan write in second reset");
		sys_rst <= 0;
		apb(REG_CTRL, 0, 0);
		chk_word(rd, 32'h0, "auto switch cleared by reset");
		apb(REG_CONFIG, 0, 0);
		chk_word(rd, 32'h0, "settings cleared by reset");
		$display("test mid-run reset done");
		report_and_stop();
	end
endmodule // pll_control_port_logic_bench
